// File: metering_adc_defs.vh
`ifndef METERING_ADC_DEFS_VH
`define METERING_ADC_DEFS_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_HZ 32'd20000000
`define MCLK_HZ 32'd4096000
`define MOD_DIV 32'd5
`define WAVE_DIV 32'd160
`define MOD_HZ (`MCLK_HZ / `MOD_DIV)
`define DECIM_RATIO (`WAVE_DIV / `MOD_DIV)
`define DECIM_CNT_W 5

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_WAVE_MODE 8'h0D
`define IDX_GAIN 8'h1F
`define IDX_IRQ_EN 8'hDB
`define IDX_IRQ_STAT 8'hDE
`define IDX_IRQ_CLR 8'hDF
`define IDX_WAVE1_LO 8'hE2
`define IDX_WAVE1_MID 8'hE3
`define IDX_WAVE1_HI 8'hE4
`define IDX_WAVE2_LO 8'hE5
`define IDX_WAVE2_MID 8'hE6
`define IDX_WAVE2_HI 8'hE7

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define GAIN_CUR_LSB 0
`define GAIN_VOLT_LSB 5
`define GAIN_MAX_CODE 3'h4
`define GAIN_RST 8'h00
`define WAVE_MODE_RST 8'h00
`define IRQ_EN_RST 8'h00
`define BIT_WAVE_READY 5
`define BIT_CLIP 4
`define STAT_MASK 8'h30

// ----------------------------------------------------------------------
// Converter codes
// ----------------------------------------------------------------------
`define FULL_SCALE_CODE 24'h20_C49B
`define MAX_CODE 24'h40_0000
`define MIN_CODE 24'hC0_0000
`define CODE_SHIFT 17

`endif

// File: sd_decimator.v
`timescale 1ns/1ns
`include "metering_adc_defs.vh"

// Integrate-and-dump low-pass over one decimation window of modulator bits
module sd_decimator (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire run_i,
    input wire bit_stb_i,
    input wire mod_bit_i,
    output reg [23:0] sample_o,
    output reg valid_o,
    output reg clip_o
);

    // ------------------------------------------------------------------
    // Window accumulation
    // ------------------------------------------------------------------
    reg [`DECIM_CNT_W-1:0] pos_r;
    reg [`DECIM_CNT_W:0] ones_r;
    wire [`DECIM_CNT_W:0] ones_nxt;
    wire [`DECIM_CNT_W+1:0] diff;
    wire signed [23:0] raw;
    wire [31:0] ratio = `DECIM_RATIO;

    assign ones_nxt = ones_r + {{`DECIM_CNT_W{1'b0}}, mod_bit_i};
    // Bipolar count: ones minus zeros over the window
    assign diff = {ones_nxt, 1'b0} - ratio[`DECIM_CNT_W+1:0];
    assign raw = {diff, {`CODE_SHIFT{1'b0}}};

    // Both channels use this same scaling, so equal bits give equal codes
    always @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            pos_r <= {`DECIM_CNT_W{1'b0}};
            ones_r <= {(`DECIM_CNT_W+1){1'b0}};
            sample_o <= 24'h00_0000;
            valid_o <= 1'b0;
            clip_o <= 1'b0;
        end else if (ce_i) begin
            valid_o <= 1'b0; // R8
            clip_o <= 1'b0;
            if (bit_stb_i) begin
                pos_r <= pos_r + 1'b1;
                if (pos_r == {`DECIM_CNT_W{1'b1}}) begin
                    ones_r <= {(`DECIM_CNT_W+1){1'b0}};
                    valid_o <= 1'b1; // R8 R9
                    // Saturate at the extreme code in either polarity
                    if (raw > $signed(`MAX_CODE)) begin
                        sample_o <= `MAX_CODE; // R11
                        clip_o <= 1'b1;
                    end else if (raw < $signed(`MIN_CODE)) begin
                        sample_o <= `MIN_CODE; // R11
                        clip_o <= 1'b1;
                    end else begin
                        sample_o <= raw; // R12
                        clip_o <= (raw == $signed(`MAX_CODE)) ||
                                  (raw == $signed(`MIN_CODE));
                    end
                end else begin
                    ones_r <= ones_nxt;
                end
            end
        end
    end

endmodule // sd_decimator

// File: metering_adc_ctrl.v
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ns
`include "metering_adc_defs.vh"

// Contract
// R1 - Current gain from gain bits 2..0
// R2 - Voltage gain from gain bits 7..5
// R3 - Gains 1, 2, 4, 8, 16 via writes
// R4 - Gain code is exponent; codes above 4 reserved
// R5 - Samples go to waveform regs and energy path
// R6 - Converters off in battery or sleep state
// R7 - Modulator bit rate is 4.096 MHz/5
// R8 - Decimating filter makes 24-bit proportional words
// R9 - Both channels share one transfer scaling
// R10 - Full-scale input nominally gives 0x20C49B
// R11 - Output magnitude limited to 4,194,304
// R12 - Signed 24-bit samples, up to 25.6 kSPS
// R13 - Two-bit rate field picks 25.6..3.2 kSPS
// R14 - Waveform regs latch on high byte read
// R15 - Ready flag set; enabled flag raises interrupt
module metering_adc_ctrl (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // Classic Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    // Power states from the power manager
    input wire battery_saving_state_i,
    input wire sleep_saving_state_i,
    // Modulator side
    input wire cur_mod_bit_i,
    input wire volt_mod_bit_i,
    output reg mod_clk_stb_o,
    output reg adc_power_down_o,
    output reg [2:0] cur_gain_o,
    output reg [2:0] volt_gain_o,
    // Energy processing path and interrupt
    output reg [23:0] cur_sample_o,
    output reg [23:0] volt_sample_o,
    output reg sample_valid_o,
    output wire irq_o
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Keep the old field when software writes a reserved code
    function [2:0] gain_pick;
        input [2:0] new_code;
        input [2:0] old_code;
        begin
            if (new_code > `GAIN_MAX_CODE)
                gain_pick = old_code;
            else
                gain_pick = new_code;
        end
    endfunction

    // Byte lane of a 24-bit sample
    function [7:0] byte_of;
        input [23:0] word;
        input [1:0] lane;
        begin
            case (lane)
                2'd0: byte_of = word[7:0];
                2'd1: byte_of = word[15:8];
                default: byte_of = word[23:16];
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg [1:0] cur_sync_r;
    reg [1:0] volt_sync_r;

    // Modulator bits are asynchronous to clk_i
    always @(posedge clk_i) begin
        if (rst_i) begin
            cur_sync_r <= 2'b00;
            volt_sync_r <= 2'b00;
        end else if (ce_i) begin
            cur_sync_r <= {cur_sync_r[0], cur_mod_bit_i};
            volt_sync_r <= {volt_sync_r[0], volt_mod_bit_i};
        end
    end

    // ------------------------------------------------------------------
    // Power control
    // ------------------------------------------------------------------
    wire run;

    assign run = !(battery_saving_state_i || sleep_saving_state_i);

    // Registered so the analog enable never glitches
    always @(posedge clk_i) begin
        if (rst_i)
            adc_power_down_o <= 1'b1;
        else if (ce_i)
            adc_power_down_o <= !run; // R6
    end

    // ------------------------------------------------------------------
    // Modulator bit clock
    // ------------------------------------------------------------------
    reg [31:0] phase_r;
    wire [31:0] phase_sum;

    // Fractional divider: 20 MHz has no integer ratio to 819.2 kHz,
    // so the strobe jitters by one cycle but keeps the exact mean rate
    assign phase_sum = phase_r + `MOD_HZ;

    always @(posedge clk_i) begin
        if (rst_i || !run) begin
            phase_r <= 32'h0000_0000;
            mod_clk_stb_o <= 1'b0;
        end else if (ce_i) begin
            if (phase_sum >= `CLK_HZ) begin
                phase_r <= phase_sum - `CLK_HZ; // R7
                mod_clk_stb_o <= 1'b1;
            end else begin
                phase_r <= phase_sum;
                mod_clk_stb_o <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Decimation filters, one per channel, identical scaling
    // ------------------------------------------------------------------
    wire [23:0] cur_dec;
    wire [23:0] volt_dec;
    wire cur_dec_vld;
    wire volt_dec_vld;
    wire cur_clip;
    wire volt_clip;

    sd_decimator u_cur_dec (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(run),
        .bit_stb_i(mod_clk_stb_o),
        .mod_bit_i(cur_sync_r[1]),
        .sample_o(cur_dec),
        .valid_o(cur_dec_vld),
        .clip_o(cur_clip)
    );

    sd_decimator u_volt_dec (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(run),
        .bit_stb_i(mod_clk_stb_o),
        .mod_bit_i(volt_sync_r[1]),
        .sample_o(volt_dec),
        .valid_o(volt_dec_vld),
        .clip_o(volt_clip)
    );

    // Energy path gets every sample, independent of waveform rate
    always @(posedge clk_i) begin
        if (rst_i) begin
            cur_sample_o <= 24'h00_0000;
            volt_sample_o <= 24'h00_0000;
            sample_valid_o <= 1'b0;
        end else if (ce_i) begin
            sample_valid_o <= cur_dec_vld; // R5
            if (cur_dec_vld) begin
                cur_sample_o <= cur_dec; // R5 R9
                volt_sample_o <= volt_dec;
            end
        end
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    reg ack_r;
    wire [7:0] idx;
    wire req;
    wire wr;
    wire rd;

    assign idx = wb_adr_i[9:2];
    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr = wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0];
    assign rd = req && !wb_we_i;
    assign wb_ack_o = ack_r;

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    reg [7:0] gain_r;
    reg [7:0] wave_mode_r;
    reg [7:0] irq_en_r;
    reg [7:0] stat_r;
    reg [7:0] stat_nxt;
    reg [2:0] rate_cnt_r;
    reg [23:0] pend_cur_r;
    reg [23:0] pend_volt_r;
    reg [23:0] wave_cur_r;
    reg [23:0] wave_volt_r;
    wire [2:0] rate_last;
    wire wave_evt;
    wire hi_read;

    // Decimated rate 25.6 kSPS divided by 1, 2, 4 or 8
    assign rate_last = (3'd1 << wave_mode_r[1:0]) - 3'd1; // R13
    assign wave_evt = cur_dec_vld && (rate_cnt_r >= rate_last);
    assign hi_read = rd && ((idx == `IDX_WAVE1_HI) ||
                            (idx == `IDX_WAVE2_HI));

    // Gain, mode and interrupt enable registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            gain_r <= `GAIN_RST;
            wave_mode_r <= `WAVE_MODE_RST;
            irq_en_r <= `IRQ_EN_RST;
        end else if (ce_i && wr) begin
            if (idx == `IDX_GAIN) begin
                gain_r[`GAIN_CUR_LSB+2:`GAIN_CUR_LSB] <= gain_pick(
                    wb_dat_i[`GAIN_CUR_LSB+2:`GAIN_CUR_LSB],
                    gain_r[`GAIN_CUR_LSB+2:`GAIN_CUR_LSB]); // R3 R4
                gain_r[`GAIN_VOLT_LSB+2:`GAIN_VOLT_LSB] <= gain_pick(
                    wb_dat_i[`GAIN_VOLT_LSB+2:`GAIN_VOLT_LSB],
                    gain_r[`GAIN_VOLT_LSB+2:`GAIN_VOLT_LSB]); // R3 R4
            end
            if (idx == `IDX_WAVE_MODE)
                wave_mode_r <= {6'd0, wb_dat_i[1:0]}; // R13
            if (idx == `IDX_IRQ_EN)
                irq_en_r <= wb_dat_i[7:0] & `STAT_MASK;
        end
    end

    // Gain fields drive the amplifiers as exponent codes
    always @(posedge clk_i) begin
        if (rst_i) begin
            cur_gain_o <= 3'd0;
            volt_gain_o <= 3'd0;
        end else if (ce_i) begin
            cur_gain_o <= gain_r[`GAIN_CUR_LSB+2:`GAIN_CUR_LSB]; // R1
            volt_gain_o <= gain_r[`GAIN_VOLT_LSB+2:`GAIN_VOLT_LSB]; // R2
        end
    end

    // Rate divider and pending sample capture
    always @(posedge clk_i) begin
        if (rst_i || !run) begin
            rate_cnt_r <= 3'd0;
            pend_cur_r <= 24'h00_0000;
            pend_volt_r <= 24'h00_0000;
        end else if (ce_i && cur_dec_vld) begin
            if (wave_evt) begin
                rate_cnt_r <= 3'd0;
                pend_cur_r <= cur_dec; // R12
                pend_volt_r <= volt_dec;
            end else begin
                rate_cnt_r <= rate_cnt_r + 3'd1;
            end
        end
    end

    // Visible copy moves only on a high byte read, so a multi-byte
    // read ending on the high byte never mixes two samples
    always @(posedge clk_i) begin
        if (rst_i) begin
            wave_cur_r <= 24'h00_0000;
            wave_volt_r <= 24'h00_0000;
        end else if (ce_i && hi_read) begin
            wave_cur_r <= pend_cur_r; // R14
            wave_volt_r <= pend_volt_r; // R14
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always @* begin
        stat_nxt = stat_r;
        if (wr && idx == `IDX_IRQ_CLR)
            stat_nxt = stat_nxt & ~wb_dat_i[7:0];
        if (wave_evt)
            stat_nxt[`BIT_WAVE_READY] = 1'b1; // R15
        if ((cur_clip || volt_clip))
            stat_nxt[`BIT_CLIP] = 1'b1;
    end

    always @(posedge clk_i) begin
        if (rst_i)
            stat_r <= 8'h00;
        else if (ce_i)
            stat_r <= stat_nxt & `STAT_MASK;
    end

    // Level interrupt while any enabled flag stands
    assign irq_o = |(stat_r & irq_en_r); // R15

    // ------------------------------------------------------------------
    // Bus answer: one wait state, zero for unmapped reads
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_r <= req;
            if (rd) begin
                case (idx)
                    `IDX_GAIN: wb_dat_o <= {24'd0, gain_r};
                    `IDX_WAVE_MODE: wb_dat_o <= {24'd0, wave_mode_r};
                    `IDX_IRQ_EN: wb_dat_o <= {24'd0, irq_en_r};
                    `IDX_IRQ_STAT: wb_dat_o <= {24'd0, stat_r};
                    `IDX_WAVE1_LO:
                        wb_dat_o <= {24'd0, byte_of(wave_cur_r, 2'd0)};
                    `IDX_WAVE1_MID:
                        wb_dat_o <= {24'd0, byte_of(wave_cur_r, 2'd1)};
                    `IDX_WAVE1_HI:
                        wb_dat_o <= {24'd0, byte_of(wave_cur_r, 2'd2)};
                    `IDX_WAVE2_LO:
                        wb_dat_o <= {24'd0, byte_of(wave_volt_r, 2'd0)};
                    `IDX_WAVE2_MID:
                        wb_dat_o <= {24'd0, byte_of(wave_volt_r, 2'd1)};
                    `IDX_WAVE2_HI:
                        wb_dat_o <= {24'd0, byte_of(wave_volt_r, 2'd2)};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // Full-scale reference code, kept for the energy path scaling
    // and for checking; nominal only, the analog side sets it
    wire [23:0] full_scale_ref = `FULL_SCALE_CODE; // R10

endmodule // metering_adc_ctrl

// File: metering_adc_checker_properties.sv
`timescale 1ns/1ns
`include "metering_adc_defs.vh"

// ----------------------------------------
// Converter block port checks
// ----------------------------------------
module metering_adc_checker (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire battery_saving_state_i,
    input wire sleep_saving_state_i,
    input wire mod_clk_stb_o,
    input wire adc_power_down_o,
    input wire [2:0] cur_gain_o,
    input wire [2:0] volt_gain_o,
    input wire [23:0] cur_sample_o,
    input wire sample_valid_o
);
    wire saving = battery_saving_state_i || sleep_saving_state_i;
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    wire gain_wr = take && wb_we_i && wb_sel_i[0] &&
        wb_adr_i[9:2] == `IDX_GAIN;
    reg [5:0] gap_r;
    reg seen_r;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Cycles since last strobe; forgotten while the divider may restart
    always @(posedge clk_i) begin
        if (rst_i || saving || adc_power_down_o) begin
            gap_r <= 6'h00;
            seen_r <= 1'b0;
        end else if (ce_i && mod_clk_stb_o) begin
            gap_r <= 6'h01;
            seen_r <= 1'b1;
        end else if (ce_i && gap_r != 6'h3F) begin
            gap_r <= gap_r + 6'h01;
        end
    end

    ack_answer_a: assert property (take |=> wb_ack_o)
        else $error("no ack next cycle");
    ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("ack longer than a cycle");
    rdata_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero off ack");
    cur_gain_a: assert property (
        gain_wr && wb_dat_i[2:0] <= `GAIN_MAX_CODE
        |-> ##3 cur_gain_o == $past(wb_dat_i[2:0], 3))
        else $error("current gain not written");
    volt_gain_a: assert property (
        gain_wr && wb_dat_i[7:5] <= `GAIN_MAX_CODE
        |-> ##3 volt_gain_o == $past(wb_dat_i[7:5], 3))
        else $error("voltage gain not written");
    gain_keep_a: assert property (
        gain_wr && wb_dat_i[7:5] > `GAIN_MAX_CODE |-> ##3 $stable(volt_gain_o))
        else $error("reserved code changed gain");
    power_down_a: assert property (saving && ce_i |=> adc_power_down_o)
        else $error("converters not powered down");
    conv_quiet_a: assert property (
        adc_power_down_o && $past(adc_power_down_o) && saving
        |-> !mod_clk_stb_o && !sample_valid_o)
        else $error("converter active while off");
    stb_spacing_a: assert property (
        mod_clk_stb_o && seen_r |-> gap_r == 6'h18 || gap_r == 6'h19)
        else $error("modulator strobe spacing off");
    sample_range_a: assert property (
        sample_valid_o |-> $signed(cur_sample_o) <= $signed(`MAX_CODE) &&
        $signed(cur_sample_o) >= $signed(`MIN_CODE))
        else $error("sample beyond extreme code");
endmodule // metering_adc_checker

bind metering_adc_ctrl metering_adc_checker metering_adc_checker_inst (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .battery_saving_state_i,
    .sleep_saving_state_i, .mod_clk_stb_o, .adc_power_down_o,
    .cur_gain_o, .volt_gain_o, .cur_sample_o, .sample_valid_o);

// File: modulator_model.sv
`timescale 1ns/1ns

// ----------------------------------------
// Two matched sigma-delta modulators
// ----------------------------------------
module modulator_model (
    input wire clk_i,
    input wire power_down_i,
    input wire stb_i,
    input wire [1:0] mode_i,
    output reg cur_bit_o = 1'b0,
    output reg volt_bit_o
);
    reg [1:0] ph_r = 2'h0;
    reg [3:0] pat;

    // Period four divides the window, so density is phase independent
    always @* begin
        case (mode_i)
            2'h0: pat = 4'h0;
            2'h1: pat = 4'hF;
            2'h2: pat = 4'hE;
            default: pat = 4'hC;
        endcase
    end

    // Unpowered streams toggle so no stale level can look valid
    always @(posedge clk_i) begin
        if (power_down_i) begin
            cur_bit_o <= ~cur_bit_o;
            volt_bit_o <= cur_bit_o;
        end else if (stb_i) begin
            ph_r <= ph_r + 2'h1;
            cur_bit_o <= pat[ph_r];
            volt_bit_o <= pat[ph_r];
        end
    end
endmodule // modulator_model

// File: tb_metering_adc_ctrl.sv
`timescale 1ns/1ns
`include "metering_adc_defs.vh"

module tb_metering_adc_ctrl;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg ce_i = 1'b1;
    reg wb_cyc_i = 1'b0;
    reg wb_stb_i = 1'b0;
    reg wb_we_i = 1'b0;
    reg [9:0] wb_adr_i = 10'h000;
    reg [3:0] wb_sel_i = 4'hF;
    reg [31:0] wb_dat_i = 32'h0000_0000;
    reg battery_saving_state_i = 1'b0;
    reg sleep_saving_state_i = 1'b0;
    reg [1:0] mode = 2'h1;
    wire [31:0] wb_dat_o;
    wire [23:0] cur_sample_o;
    wire [23:0] volt_sample_o;
    wire [2:0] cur_gain_o;
    wire [2:0] volt_gain_o;
    wire wb_ack_o, cur_bit, volt_bit, mod_clk_stb_o;
    wire adc_power_down_o, sample_valid_o, irq_o;
    integer n_mismatch = 0, cmp_count = 0, cycles = 0;
    integer i, n, p;
    reg [7:0] q;

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    metering_adc_ctrl metering_adc_ctrl_inst (.clk_i, .rst_i, .ce_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .battery_saving_state_i,
        .sleep_saving_state_i, .cur_mod_bit_i(cur_bit),
        .volt_mod_bit_i(volt_bit), .mod_clk_stb_o, .adc_power_down_o,
        .cur_gain_o, .volt_gain_o, .cur_sample_o, .volt_sample_o,
        .sample_valid_o, .irq_o);

    modulator_model modulator_model_inst (.clk_i,
        .power_down_i(adc_power_down_o), .stb_i(mod_clk_stb_o),
        .mode_i(mode), .cur_bit_o(cur_bit), .volt_bit_o(volt_bit));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task conclude;
        begin
            $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
            if (n_mismatch == 0 && cmp_count > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    task chk(input string name, input [23:0] exp, input [23:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] %s expected %h seen %h", name, exp, got);
            end
        end
    endtask

    // One classic cycle; held until ack is sampled, then released
    task xfer(input w, input [7:0] idx, input [7:0] d);
        begin
            @(posedge clk_i);
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= w;
            wb_adr_i <= {idx, 2'b00};
            wb_dat_i <= {24'h00_0000, d};
            @(posedge clk_i);
            while (wb_ack_o !== 1'b1) @(posedge clk_i);
            q = wb_dat_o[7:0];
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
        end
    endtask

    task wait_valid;
        begin
            @(posedge clk_i);
            while (sample_valid_o !== 1'b1) @(posedge clk_i);
        end
    endtask

    task wait_irq;
        begin
            n = 0;
            @(posedge clk_i);
            while (irq_o !== 1'b1) begin
                @(posedge clk_i);
                n = n + 1;
            end
        end
    endtask

    task level(input [1:0] m, input [23:0] exp);
        begin
            mode <= m;
            repeat (3) wait_valid;
            chk("cur sample", exp, cur_sample_o);
            chk("volt sample", exp, volt_sample_o);
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        begin
            chk("power down in reset", 1, adc_power_down_o);
            repeat (3) @(posedge clk_i);
            chk("power down after", 0, adc_power_down_o);
            xfer(0, `IDX_GAIN, 0);
            chk("gain reset", `GAIN_RST, q);
            xfer(0, `IDX_WAVE_MODE, 0);
            chk("mode reset", `WAVE_MODE_RST, q);
            xfer(0, `IDX_IRQ_EN, 0);
            chk("enable reset", `IRQ_EN_RST, q);
            xfer(1, `IDX_IRQ_STAT, 8'hFF);
            xfer(0, `IDX_IRQ_STAT, 0);
            chk("status read only", 0, q);
            xfer(0, 8'h40, 0);
            chk("unmapped read", 0, q);
            chk("irq idle", 0, irq_o);
            $display("test reset done");
        end
    endtask

    task t_gain;
        begin
            for (i = 0; i < 5; i = i + 1) begin
                n = 4 - i;
                xfer(1, `IDX_GAIN, {i[2:0], 2'b00, n[2:0]});
                xfer(0, `IDX_GAIN, 0);
                chk("cur gain", n, cur_gain_o);
                chk("volt gain", i, volt_gain_o);
                chk("gain read", {i[2:0], 2'b00, n[2:0]}, q);
            end
            // Both fields reserved: both keep their codes
            xfer(1, `IDX_GAIN, 8'hBF);
            repeat (2) @(posedge clk_i);
            chk("cur keep", 0, cur_gain_o);
            chk("volt keep", 4, volt_gain_o);
            $display("test gain done");
        end
    endtask

    task t_levels;
        begin
            level(1, `MAX_CODE);
            level(0, `MIN_CODE);
            xfer(0, `IDX_IRQ_STAT, 0);
            chk("clip flag", 1, q[`BIT_CLIP]);
            level(2, 24'h20_0000);
            n = `FULL_SCALE_CODE - cur_sample_o;
            chk("near full scale", 1, n >= 0 && n < 131072);
            level(3, 24'h00_0000);
            $display("test levels done");
        end
    endtask

    task t_wave;
        begin
            level(1, `MAX_CODE);
            xfer(1, `IDX_IRQ_EN, 8'h20);
            xfer(1, `IDX_IRQ_CLR, 8'hFF);
            wait_irq;
            xfer(0, `IDX_IRQ_STAT, 0);
            chk("ready flag", 1, q[`BIT_WAVE_READY]);
            xfer(0, `IDX_WAVE1_HI, 0);
            xfer(0, `IDX_WAVE1_HI, 0);
            chk("wave1 hi", 8'h40, q);
            xfer(0, `IDX_WAVE1_MID, 0);
            chk("wave1 mid", 0, q);
            xfer(0, `IDX_WAVE2_HI, 0);
            chk("wave2 hi", 8'h40, q);
            level(0, `MIN_CODE);
            xfer(0, `IDX_WAVE2_LO, 0);
            chk("wave2 lo", 0, q);
            xfer(0, `IDX_WAVE2_HI, 0);
            chk("wave2 held", 8'h40, q);
            xfer(0, `IDX_WAVE1_HI, 0);
            chk("wave1 new", 8'hC0, q);
            chk("irq pending", 1, irq_o);
            xfer(1, `IDX_IRQ_CLR, 8'h20);
            @(posedge clk_i);
            chk("irq cleared", 0, irq_o);
            xfer(1, `IDX_IRQ_EN, 8'h00);
            q = 0;
            while (q[`BIT_WAVE_READY] !== 1'b1) xfer(0, `IDX_IRQ_STAT, 0);
            chk("irq masked", 0, irq_o);
            $display("test wave done");
        end
    endtask

    task t_rate;
        begin
            xfer(1, `IDX_IRQ_EN, 8'h20);
            for (i = 0; i < 4; i = i + 1) begin
                xfer(1, `IDX_WAVE_MODE, i[7:0]);
                repeat (3) begin
                    wait_irq;
                    xfer(1, `IDX_IRQ_CLR, 8'h20);
                end
                wait_irq;
                p = (3125 << i) / 4;
                chk("rate period", 1, n > p - 40 && n < p + 10);
            end
            $display("test rate done");
        end
    endtask

    task t_power;
        begin
            battery_saving_state_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            chk("battery off", 1, adc_power_down_o);
            n = 0;
            repeat (2000) begin
                @(posedge clk_i);
                if (sample_valid_o === 1'b1) n = n + 1;
            end
            chk("no samples off", 0, n);
            battery_saving_state_i <= 1'b0;
            sleep_saving_state_i <= 1'b1;
            repeat (2) @(posedge clk_i);
            chk("sleep off", 1, adc_power_down_o);
            sleep_saving_state_i <= 1'b0;
            repeat (3) @(posedge clk_i);
            chk("power back", 0, adc_power_down_o);
            wait_valid;
            $display("test power done");
        end
    endtask

    // Hang guard well above the run length
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles == 90000) begin
            n_mismatch = n_mismatch + 1;
            $display("[FAIL] run length expected 90000 seen %0d", cycles);
            conclude;
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_gain;
        t_levels;
        t_wave;
        t_rate;
        t_power;
        conclude;
    end
endmodule // tb_metering_adc_ctrl
